// >>> ivc_defs.svh
// named constants for the interrupt vector and enable block
`ifndef IVC_DEFS_SVH
`define IVC_DEFS_SVH
// register offsets on the byte-wide sfr port
`define IVC_OFS_IE1       8'h00
`define IVC_OFS_IE2       8'h01
`define IVC_OFS_IRQ_STAT  8'h04
`define IVC_OFS_IRQ_MASK  8'h05
`define IVC_OFS_RST_CAUSE 8'h06
// enable register bit positions
`define IVC_IE_WDT        0
`define IVC_IE_OF         1
`define IVC_IE_NMI        4
`define IVC_IE_ACCV       5
`define IVC_IE_PRESENT    8'h33
`define IVC_IE_RESET      8'h00
// vector table
`define IVC_VEC_BASE      16'hFFC0
`define IVC_ERASED_WORD   16'hFFFF
`define IVC_PRIO_RESET    5'h1F
`define IVC_PRIO_NMI      5'h1E
`define IVC_PRIO_WDT      5'h1A
`define IVC_PRIO_TCH0     5'h19
`define IVC_PRIO_TOTH     5'h18
`define IVC_PRIO_SERIAL   5'h14
`define IVC_PRIO_P2       5'h13
`define IVC_PRIO_P1       5'h12
// fetchable memory ranges
`define IVC_PERIPH_END    16'h01FF
`define IVC_RAM_LO        16'h0200
`define IVC_RAM_HI        16'h02FF
`define IVC_INFO_LO       16'h1000
`define IVC_INFO_HI       16'h10FF
`define IVC_CODE_LO       16'hF000
// interrupt status bits
`define IVC_ST_FETCH      0
`define IVC_ST_NMI        1
`define IVC_ST_OSC        2
`define IVC_ST_ACCV       3
`define IVC_ST_SLEEP      4
`define IVC_ST_W          5
// reset cause bits
`define IVC_CA_POR        0
`define IVC_CA_EXT        1
`define IVC_CA_WDT        2
`define IVC_CA_KEY        3
`define IVC_CA_PCOOR      4
`define IVC_CA_W          5
`define IVC_CA_RESET      5'h01
`endif

// >>> ivc_pkg.sv
// types shared by the interrupt vector block
package ivc_pkg;
  typedef enum logic [2:0]
  {
    ST_BOOT  = 3'b001,
    ST_RUN   = 3'b010,
    ST_SLEEP = 3'b100
  } boot_state_e;
  typedef logic [31:0] prio_vec_t;
endpackage

// >>> prio_if.sv
// request vector and arbitration result between controller and arbiter
`timescale 1ns/1ps
interface prio_if;
  ivc_pkg::prio_vec_t req;   // one bit per priority level
  logic               any;   // some level requests
  logic [4:0]         idx;   // highest requesting level
  modport arb (input req, output any, idx);
  modport ctl (output req, input any, idx);
endinterface

// >>> prio_arbiter.sv
// fixed-priority picker: highest level number wins
`timescale 1ns/1ps
module prio_arbiter
  import ivc_pkg::*;
(
  prio_if.arb pif  // requests in, winner out
);
  // scan upward so the last hit is the highest level
  always_comb
  begin
    pif.any = 1'b0;
    pif.idx = 5'h00;
    for (int i = 0; i < 32; i++)
    begin
      if (pif.req[i])
      begin
        pif.any = 1'b1;
        pif.idx = 5'(i);
      end
    end
  end
endmodule

// >>> int_vector_ctrl.sv
// interrupt vectoring, reset sourcing and system enable register
//
// Design decision made here: strobed register access.
`timescale 1ns/1ps
`include "ivc_defs.svh"
module int_vector_ctrl
  import ivc_pkg::*;
(
  input  wire logic        mclk,          // system clock
  input  wire logic        sys_rst,       // power-on reset, async high
  input  wire logic        clkEn,         // freezes all state when low
  input  wire logic [7:0]  regAddr,       // sfr byte address
  input  wire logic [7:0]  regWdata,      // sfr write data
  input  wire logic        regWr,         // write strobe
  input  wire logic        regRd,         // read strobe
  output logic      [7:0]  regRdata,      // read data, cycle after strobe
  input  wire logic        rstPinN,       // external reset pin, async
  input  wire logic        nmiPin,        // external nmi pin, async
  input  wire logic        nmiMode,       // pin acts as nmi, not reset
  input  wire logic        wdtEvent,      // watchdog expiry pulse
  input  wire logic        wdtInterval,   // watchdog in interval mode
  input  wire logic        keyViolation,  // flash key violation pulse
  input  wire logic        oscFault,      // oscillator fault level
  input  wire logic        accViolation,  // flash access violation level
  input  wire logic        timerCh0Flag,  // timer channel zero flag
  input  wire logic        timerOthFlag,  // timer ch1/ch2/overflow flags
  input  wire logic        serialFlag,    // serial interface flags
  input  wire logic [7:0]  port1Flags,    // port one pin flags
  input  wire logic [7:0]  port2Flags,    // port two pin flags
  input  wire logic        gie,           // core global enable
  input  wire logic        fetchValid,    // core fetches an instruction
  input  wire logic [15:0] fetchAddr,     // fetch address
  input  wire logic [15:0] resetVecWord,  // content of the reset vector
  input  wire logic        irqAck,        // core takes the offered vector
  input  wire logic        irqReturn,     // core returns from handler
  input  wire logic [2:0]  lpmIn,         // core low-power mode now
  output logic             irqReq,        // interrupt offered to core
  output logic      [15:0] irqVector,     // vector word address
  output logic      [4:0]  irqLevel,      // priority of offered vector
  output logic             sysResetOut,   // power-up clear, registered reset sources
  output logic             deepSleep,     // core held in deepest sleep
  output logic             wakeReq,       // leave low-power mode
  output logic      [2:0]  restoreLpm,    // mode to resume on return
  output logic             sysIrq         // level status interrupt
);

  //////////////////////////////////////////////////////////////////////
  // helpers

  // vector word of a level: base plus two bytes per level
  function automatic logic [15:0] vecOf(input logic [4:0] lvl);
    vecOf = `IVC_VEC_BASE | {10'h000, lvl, 1'b0};
  endfunction

  // only ram, info flash and code flash may be fetched from
  function automatic logic fetchLegal(input logic [15:0] a);
    fetchLegal = (a >= `IVC_RAM_LO && a <= `IVC_RAM_HI) ||
                 (a >= `IVC_INFO_LO && a <= `IVC_INFO_HI) ||
                 (a >= `IVC_CODE_LO);
  endfunction

  //////////////////////////////////////////////////////////////////////
  // declarations

  logic              rstPinMeta;     // first sync stage, reset pin
  logic              rstPinSync;     // second sync stage, reset pin
  logic              nmiMeta;        // first sync stage, nmi pin
  logic              nmiSync;        // second sync stage, nmi pin
  logic              nmiDly;         // delayed copy for edge detect
  logic              nmiEdge;        // rising nmi pin event
  logic              nmiFlag_reg;    // latched nmi pin event
  logic              oscDly;         // delayed oscillator fault
  logic              accDly;         // delayed access violation
  logic [7:0]        ie1_reg;        // enable register, present bits
  logic [`IVC_ST_W-1:0] stat_reg;    // sticky event status
  logic [`IVC_ST_W-1:0] mask_reg;    // status interrupt mask
  logic [`IVC_ST_W-1:0] statSet;     // status set terms
  logic [`IVC_CA_W-1:0] cause_reg;   // reset source flags
  logic [`IVC_CA_W-1:0] causeSet;    // reset source set terms
  logic              badFetch;       // fetch outside legal memory
  logic              wdtReset;       // watchdog expiry in watchdog mode
  logic              extReset;       // reset pin low in reset mode
  logic              pucReq;         // any reset source this cycle
  boot_state_e       state_reg;      // boot check state
  boot_state_e       state_next;     // next boot check state
  logic              wrHit;          // write strobe, taken as is
  prio_if            pif ();         // arbiter connection

  //////////////////////////////////////////////////////////////////////
  // pin synchronisers

  // two flops before any logic sees a pin
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rstPinMeta <= 1'b1;
      rstPinSync <= 1'b1;
      nmiMeta    <= 1'b0;
      nmiSync    <= 1'b0;
      nmiDly     <= 1'b0;
    end
    else if (clkEn)
    begin
      rstPinMeta <= rstPinN;
      rstPinSync <= rstPinMeta;
      nmiMeta    <= nmiPin;
      nmiSync    <= nmiMeta;
      nmiDly     <= nmiSync;
    end
  end

  // edge of the settled nmi level
  assign nmiEdge = nmiMode && nmiSync && !nmiDly;

  //////////////////////////////////////////////////////////////////////
  // reset sources

  assign badFetch = fetchValid && !fetchLegal(fetchAddr);
  // expiry resets only in watchdog mode
  assign wdtReset = wdtEvent && !wdtInterval;
  // pin resets only when not used as nmi
  assign extReset = !nmiMode && !rstPinSync;

  // each reset source sets its own flag
  always_comb
  begin
    causeSet                  = '0;
    causeSet[`IVC_CA_EXT]     = extReset;
    causeSet[`IVC_CA_WDT]     = wdtReset;
    causeSet[`IVC_CA_KEY]     = keyViolation;
    causeSet[`IVC_CA_PCOOR]   = badFetch;
  end

  assign pucReq = |causeSet;

  // reset cause flags survive power-up clear; power-on leaves only the power-on flag, a software write overwrites them
  // bracketed bits reset by power-on
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cause_reg <= `IVC_CA_RESET;
    end
    else if (clkEn)
    begin
      // software write first, a new source still wins
      if (wrHit && regAddr == `IVC_OFS_RST_CAUSE)
      begin
        cause_reg <= regWdata[`IVC_CA_W-1:0] | causeSet;
      end
      else
      begin
        cause_reg <= cause_reg | causeSet;
      end
    end
  end

  // clear pulse to the rest of the chip, one cycle after any reset source and as long as it lasts
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sysResetOut <= 1'b1;
    end
    else if (clkEn)
    begin
      sysResetOut <= pucReq;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // boot check of the reset vector

  // erased reset vector parks the core
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_BOOT:
      begin
        if (resetVecWord == `IVC_ERASED_WORD)
        begin
          state_next = ST_SLEEP;
        end
        else
        begin
          state_next = ST_RUN;
        end
      end
      ST_RUN:   state_next = ST_RUN;
      ST_SLEEP: state_next = ST_SLEEP;
      default:  state_next = ST_BOOT;
    endcase
    // any reset source restarts the check
    if (pucReq)
    begin
      state_next = ST_BOOT;
    end
  end

  // state register
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_reg <= ST_BOOT;
    end
    else if (clkEn)
    begin
      state_reg <= state_next;
    end
  end

  // sleep stays until a reset, no interrupt can leave it
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      deepSleep <= 1'b0;
    end
    else if (clkEn)
    begin
      deepSleep <= (state_next == ST_SLEEP);
    end
  end

  //////////////////////////////////////////////////////////////////////
  // enable register

  assign wrHit = regWr;

  // four enables, cleared by power-up clear
  // absent bits masked off, never stored
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ie1_reg <= `IVC_IE_RESET;
    end
    else if (clkEn)
    begin
      if (pucReq)
      begin
        ie1_reg <= `IVC_IE_RESET;
      end
      else if (wrHit && regAddr == `IVC_OFS_IE1)
      begin
        ie1_reg <= regWdata & `IVC_IE_PRESENT;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // non-maskable sources

  // nmi pin event held until the core takes its vector
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      nmiFlag_reg <= 1'b0;
    end
    else if (clkEn)
    begin
      // a new edge wins over the acknowledge
      if (nmiEdge)
      begin
        nmiFlag_reg <= 1'b1;
      end
      else if (irqAck && irqLevel == `IVC_PRIO_NMI)
      begin
        nmiFlag_reg <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // request vector to the arbiter

  // peripheral flags arrive as levels from their modules
  always_comb
  begin
    pif.req = '0;
    // own enables only, global enable ignored
    pif.req[`IVC_PRIO_NMI] = (nmiFlag_reg && ie1_reg[`IVC_IE_NMI]) ||
                             (oscFault && ie1_reg[`IVC_IE_OF]) ||
                             (accViolation && ie1_reg[`IVC_IE_ACCV]);
    pif.req[`IVC_PRIO_WDT]    = gie && wdtInterval && wdtEvent &&
                                ie1_reg[`IVC_IE_WDT];
    pif.req[`IVC_PRIO_TCH0]   = gie && timerCh0Flag;
    pif.req[`IVC_PRIO_TOTH]   = gie && timerOthFlag;
    pif.req[`IVC_PRIO_SERIAL] = gie && serialFlag;
    pif.req[`IVC_PRIO_P2]     = gie && (|port2Flags);
    pif.req[`IVC_PRIO_P1]     = gie && (|port1Flags);
    // levels 15 to 0 stay zero
  end

  prio_arbiter u_arb
  (
    .pif (pif)
  );

  //////////////////////////////////////////////////////////////////////
  // vector offer to the core

  // offer re-evaluated each cycle so a newer higher level overtakes;
  // losers simply stay pending in their own flags; a losing watchdog interval pulse is not held and is lost
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      irqReq    <= 1'b0;
      irqLevel  <= `IVC_PRIO_RESET;
      irqVector <= `IVC_VEC_BASE | 16'h003E;
    end
    else if (clkEn)
    begin
      if (pucReq)
      begin
        irqReq    <= 1'b0;
        irqLevel  <= `IVC_PRIO_RESET;
        irqVector <= vecOf(`IVC_PRIO_RESET);
      end
      // a parked core never runs handlers
      else if (state_next == ST_SLEEP || irqAck)
      begin
        irqReq <= 1'b0;
      end
      else
      begin
        irqReq    <= pif.any;
        irqLevel  <= pif.idx;
        irqVector <= vecOf(pif.idx);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // low-power wake and return

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wakeReq    <= 1'b0;
      restoreLpm <= 3'h0;
    end
    else if (clkEn)
    begin
      wakeReq <= pif.any && !pucReq && state_next != ST_SLEEP;
      // mode saved on accept, held unchanged on return
      if (pucReq)
      begin
        restoreLpm <= 3'h0;
      end
      else if (irqAck)
      begin
        restoreLpm <= lpmIn;
      end
      else if (irqReturn)
      begin
        restoreLpm <= restoreLpm;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // status interrupt

  // event strobes; rising edges so a level fault reports once
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      oscDly <= 1'b0;
      accDly <= 1'b0;
    end
    else if (clkEn)
    begin
      oscDly <= oscFault;
      accDly <= accViolation;
    end
  end

  always_comb
  begin
    statSet                 = '0;
    statSet[`IVC_ST_FETCH]  = badFetch;
    statSet[`IVC_ST_NMI]    = nmiEdge;
    statSet[`IVC_ST_OSC]    = oscFault && !oscDly;
    statSet[`IVC_ST_ACCV]   = accViolation && !accDly;
    statSet[`IVC_ST_SLEEP]  = (state_reg == ST_BOOT) &&
                              (state_next == ST_SLEEP);
  end

  // sticky bits, write one to clear, set beats clear
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      stat_reg <= '0;
    end
    else if (clkEn)
    begin
      if (wrHit && regAddr == `IVC_OFS_IRQ_STAT)
      begin
        stat_reg <= (stat_reg & ~regWdata[`IVC_ST_W-1:0]) | statSet;
      end
      else
      begin
        stat_reg <= stat_reg | statSet;
      end
    end
  end

  // mask register, survives power-up clear
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      mask_reg <= '0;
    end
    else if (clkEn && wrHit && regAddr == `IVC_OFS_IRQ_MASK)
    begin
      mask_reg <= regWdata[`IVC_ST_W-1:0];
    end
  end

  // level output, one cycle behind the status bits
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sysIrq <= 1'b0;
    end
    else if (clkEn)
    begin
      sysIrq <= |(stat_reg & mask_reg);
    end
  end

  //////////////////////////////////////////////////////////////////////
  // register read port

  // data valid only the cycle after the strobe, zero otherwise
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      regRdata <= 8'h00;
    end
    else if (clkEn)
    begin
      if (!regRd)
      begin
        regRdata <= 8'h00;
      end
      else if (regAddr == `IVC_OFS_IE1)
      begin
        regRdata <= ie1_reg;
      end
      else if (regAddr == `IVC_OFS_IRQ_STAT)
      begin
        regRdata <= {{(8-`IVC_ST_W){1'b0}}, stat_reg};
      end
      else if (regAddr == `IVC_OFS_IRQ_MASK)
      begin
        regRdata <= {{(8-`IVC_ST_W){1'b0}}, mask_reg};
      end
      else if (regAddr == `IVC_OFS_RST_CAUSE)
      begin
        regRdata <= {{(8-`IVC_CA_W){1'b0}}, cause_reg};
      end
      // second enable register and unmapped read zero
      else
      begin
        regRdata <= 8'h00;
      end
    end
  end

endmodule

// >>> int_vector_ctrl_properties.sv
// assertion checker for the interrupt vector and enable block
`timescale 1ns/1ps
module int_vector_ctrl_props (
  input wire logic        mclk,         // system clock
  input wire logic        sys_rst,      // async reset
  input wire logic        regRd,        // read strobe
  input wire logic [7:0]  regAddr,      // sfr address
  input wire logic [7:0]  regRdata,     // read data
  input wire logic        wdtEvent,     // watchdog expiry
  input wire logic        wdtInterval,  // interval mode
  input wire logic        keyViolation, // key violation
  input wire logic        timerCh0Flag, // channel zero flag
  input wire logic [7:0]  port2Flags,   // port two flags
  input wire logic        gie,          // global enable
  input wire logic        fetchValid,   // fetch strobe
  input wire logic [15:0] fetchAddr,    // fetch address
  input wire logic        irqReq,       // offer to core
  input wire logic [15:0] irqVector,    // offered word
  input wire logic [4:0]  irqLevel,     // offered level
  input wire logic        sysResetOut,  // power-up clear
  input wire logic        deepSleep,    // erased vector
  input wire logic        wakeReq       // wake request
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  //////////////////////////////
  property p_vec_word;
    irqReq |-> irqVector == 16'hFFC0 + {10'h000, irqLevel, 1'b0};
  endproperty
  a_vec_word: assert property (p_vec_word) else $error("vector word off");
  property p_no_low;
    irqReq |-> irqLevel > 5'h0F;
  endproperty
  a_no_low: assert property (p_no_low) else $error("unused level offered");
  property p_sfr_bits;
    $past(regRd && regAddr <= 8'h01) |-> (regRdata & ($past(regAddr) == 8'h01 ? 8'hFF : 8'hCC)) == 8'h00;
  endproperty
  a_sfr_bits: assert property (p_sfr_bits) else $error("absent bit reads one");
  property p_bad_fetch;
    $past(fetchValid && fetchAddr <= 16'h01FF) |-> sysResetOut;
  endproperty
  a_bad_fetch: assert property (p_bad_fetch) else $error("bad fetch kept running");
  property p_rst_src;
    $past(keyViolation || (wdtEvent && !wdtInterval)) |-> sysResetOut && !irqReq;
  endproperty
  a_rst_src: assert property (p_rst_src) else $error("reset source ignored");
  property p_sleep;
    deepSleep |-> !irqReq;
  endproperty
  a_sleep: assert property (p_sleep) else $error("offer while asleep");
  property p_wake;
    irqReq |-> wakeReq;
  endproperty
  a_wake: assert property (p_wake) else $error("offer without wake");
  property p_tch0;
    irqReq && irqLevel == 5'h18 |-> !$past(gie && timerCh0Flag);
  endproperty
  a_tch0: assert property (p_tch0) else $error("lower timer level won");
  property p_port;
    irqReq && irqLevel == 5'h12 |-> !$past(gie && |port2Flags);
  endproperty
  a_port: assert property (p_port) else $error("port one beat port two");
  // main scenarios reached
  c_nmi: cover property (irqReq && irqLevel == 5'h1E);
  c_sleep: cover property (deepSleep);
  c_rst: cover property ($rose(sysResetOut));
endmodule
bind int_vector_ctrl int_vector_ctrl_props u_props (.mclk(mclk), .sys_rst(sys_rst), .regRd(regRd),
  .regAddr(regAddr), .regRdata(regRdata), .wdtEvent(wdtEvent), .wdtInterval(wdtInterval),
  .keyViolation(keyViolation), .timerCh0Flag(timerCh0Flag), .port2Flags(port2Flags), .gie(gie),
  .fetchValid(fetchValid), .fetchAddr(fetchAddr), .irqReq(irqReq), .irqVector(irqVector),
  .irqLevel(irqLevel), .sysResetOut(sysResetOut), .deepSleep(deepSleep), .wakeReq(wakeReq));

// >>> cpu_core_model.sv
// behavioural cpu core that takes offered vectors
`timescale 1ns/1ps
module cpu_core_model (
  input  wire logic        mclk,      // system clock
  input  wire logic        sys_rst,   // async reset
  input  wire logic        irqReq,    // vector offered
  input  wire logic [15:0] irqVector, // offered word
  input  wire logic [3:0]  ackDelay,  // cycles before taking
  output logic             irqAck,    // take pulse
  output logic             irqReturn, // return pulse
  output logic      [15:0] takenVec   // last word taken
);
  logic [3:0] waitCnt; // cycles the offer stood
  // take only a standing offer, once; empty handler returns at once
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      irqAck    <= 1'b0;
      irqReturn <= 1'b0;
      takenVec  <= 16'h0000;
      waitCnt   <= 4'h0;
    end
    else
    begin
      irqReturn <= irqAck;
      irqAck    <= 1'b0;
      // offer gone or just taken
      if (!irqReq || irqAck)
        waitCnt <= 4'h0;
      else if (waitCnt == ackDelay)
      begin
        irqAck   <= 1'b1;
        takenVec <= irqVector;
        waitCnt  <= 4'h0;
      end
      else
        waitCnt <= waitCnt + 4'h1;
    end
  end
endmodule

// >>> test_interrupt_vector_and_enable_sfr.sv
// self-checking bench for the interrupt vector and enable block
`timescale 1ns/1ps
`include "ivc_defs.svh"
module test_interrupt_vector_and_enable_sfr;
  logic        mclk, sys_rst, regWr, regRd, rstPinN, nmiMode, wdtEvent, wdtInterval, keyViolation, clkEn;
  logic        gie, fetchValid, irqAck, irqReturn, irqReq, sysResetOut, deepSleep, wakeReq, sysIrq, seen;
  logic [7:0]  regAddr, regWdata, regRdata, src, cause;
  logic [15:0] fetchAddr, resetVecWord, irqVector, takenVec;
  logic [2:0]  lpmIn, restoreLpm;
  logic [4:0]  irqLevel;
  logic [3:0]  ackDelay;
  int          bad_count, n_compared, tick;
  int_vector_ctrl u_dut (.mclk(mclk), .sys_rst(sys_rst), .clkEn(clkEn), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .rstPinN(rstPinN), .nmiPin(src[7]), .nmiMode(nmiMode),
    .wdtEvent(wdtEvent), .wdtInterval(wdtInterval), .keyViolation(keyViolation), .oscFault(src[5]),
    .accViolation(src[6]), .timerCh0Flag(src[0]), .timerOthFlag(src[1]), .serialFlag(src[2]),
    .port1Flags({7'h00, src[4]}), .port2Flags({src[3], 7'h00}), .gie(gie), .fetchValid(fetchValid),
    .fetchAddr(fetchAddr), .resetVecWord(resetVecWord), .irqAck(irqAck), .irqReturn(irqReturn),
    .lpmIn(lpmIn), .irqReq(irqReq), .irqVector(irqVector), .irqLevel(irqLevel), .sysResetOut(sysResetOut),
    .deepSleep(deepSleep), .wakeReq(wakeReq), .restoreLpm(restoreLpm), .sysIrq(sysIrq));
  cpu_core_model u_core (.mclk(mclk), .sys_rst(sys_rst), .irqReq(irqReq), .irqVector(irqVector),
    .ackDelay(ackDelay), .irqAck(irqAck), .irqReturn(irqReturn), .takenVec(takenVec));
  //////////////////////////////
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    regWr    <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask
  // data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge mclk);
    regRd <= 1'b0;
    #1;
    chk("sfr read", {8'h00, e}, {8'h00, regRdata});
  endtask
  // raise sources, wait for the core to take, then drop them
  task automatic irq(input logic [7:0] s, input logic [15:0] ev);
    int k;
    @(posedge mclk);
    src <= s;
    k = 0;
    while (irqAck !== 1'b1 && k < 40)
    begin
      @(posedge mclk);
      k++;
    end
    src <= 8'h00;
    chk("vector", ev, takenVec);
  endtask
  //////////////////////////////
  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // hang guard, well above the expected run
  always @(posedge mclk)
  begin
    tick <= tick + 1;
    if (tick == 4000)
    begin
      bad_count++;
      wrap_up();
    end
  end
  initial
  begin
    {regWr, regRd, wdtEvent, wdtInterval, keyViolation, gie, fetchValid} = 7'h00;
    {regAddr, regWdata, src, fetchAddr, lpmIn, ackDelay} = 47'h0;
    {sys_rst, rstPinN, nmiMode, clkEn} = 4'hF;
    resetVecWord = 16'hF000;
    bad_count = 0;
    n_compared = 0;
    cyc(10);
    sys_rst <= 1'b0;
    cyc(3);
    #1;
    chk("sleep", 16'h0000, {15'h0000, deepSleep});
    rd(`IVC_OFS_IE1, 8'h00);
    rd(`IVC_OFS_IE2, 8'h00);
    rd(`IVC_OFS_RST_CAUSE, 8'h01);
    wr(`IVC_OFS_IE1, 8'hFF);
    rd(`IVC_OFS_IE1, 8'h33);
    // a write while the clock enable is low must not land
    clkEn <= 1'b0;
    wr(`IVC_OFS_IE1, 8'h00);
    clkEn <= 1'b1;
    rd(`IVC_OFS_IE1, 8'h33);
    wr(`IVC_OFS_IRQ_STAT, 8'hFF);
    gie <= 1'b1;
    lpmIn <= 3'h3;
    irq(8'h01, 16'hFFF2);
    #1;
    chk("restore", 16'h0003, {13'h0000, restoreLpm});
    ackDelay <= 4'h3;
    irq(8'h02, 16'hFFF0);
    irq(8'h04, 16'hFFE8);
    irq(8'h08, 16'hFFE6);
    irq(8'h10, 16'hFFE4);
    irq(8'h18, 16'hFFE6);
    irq(8'h11, 16'hFFF2);
    gie <= 1'b0;
    irq(8'h20, 16'hFFFC);
    irq(8'h40, 16'hFFFC);
    irq(8'h80, 16'hFFFC);
    rd(`IVC_OFS_IRQ_STAT, 8'h0E);
    wr(`IVC_OFS_IRQ_MASK, 8'h04);
    cyc(1);
    #1;
    chk("sysirq", 16'h0001, {15'h0000, sysIrq});
    wr(`IVC_OFS_IRQ_STAT, 8'h04);
    cyc(1);
    #1;
    chk("sysirq", 16'h0000, {15'h0000, sysIrq});
    // own enable cleared blocks the oscillator fault of the nmi group
    wr(`IVC_OFS_IE1, 8'h01);
    @(posedge mclk);
    src <= 8'h20;
    cyc(6);
    #1;
    chk("offer", 16'h0000, {15'h0000, irqReq});
    src <= 8'h00;
    wdtInterval <= 1'b1;
    gie <= 1'b1;
    @(posedge mclk);
    wdtEvent <= 1'b1;
    @(posedge mclk);
    wdtEvent <= 1'b0;
    #1;
    chk("level", 16'h001A, {11'h000, irqLevel});
    chk("wake", 16'h0001, {15'h0000, wakeReq});
    cyc(8);
    wdtInterval <= 1'b0;
    nmiMode <= 1'b0;
    // pin, watchdog, key, low fetch, unused fetch, legal fetch
    for (int i = 0; i < 6; i++)
    begin
      cause = (i < 5) ? (8'h02 << (i > 3 ? 3 : i)) : 8'h00;
      wr(`IVC_OFS_RST_CAUSE, 8'h00);
      wr(`IVC_OFS_IE1, 8'h33);
      seen = 1'b0;
      @(posedge mclk);
      rstPinN      <= (i != 0);
      wdtEvent     <= (i == 1);
      keyViolation <= (i == 2);
      fetchValid   <= (i > 2);
      fetchAddr    <= (i == 3) ? 16'h01FF : (i == 4) ? 16'h0300 : 16'h0200;
      @(posedge mclk);
      {wdtEvent, keyViolation, fetchValid} <= 3'h0;
      rstPinN <= 1'b1;
      repeat (6)
      begin
        @(posedge mclk);
        seen = seen | sysResetOut;
      end
      chk("reset", {15'h0000, cause != 8'h00}, {15'h0000, seen});
      rd(`IVC_OFS_RST_CAUSE, cause);
      rd(`IVC_OFS_IE1, (i < 5) ? 8'h00 : 8'h33);
    end
    // erased reset vector at power-up
    resetVecWord <= 16'hFFFF;
    sys_rst <= 1'b1;
    cyc(2);
    sys_rst <= 1'b0;
    cyc(3);
    #1;
    chk("sleep", 16'h0001, {15'h0000, deepSleep});
    src <= 8'h01;
    cyc(6);
    #1;
    chk("offer", 16'h0000, {15'h0000, irqReq});
    wrap_up();
  end
endmodule
